// [core/asf_status_regs.sv]
// Contract
// - status bits 23..16 mirror each channel result overrun bit.
// - status bits 15..8 mirror each channel result valid bit.
// - while busy, bits 6..4 show the channel being converted.
// - while idle, bits 6..4 show the channel to convert next.
// - bit 3 reads busy, mirroring the conversion start bit.
// - compare flag one sets when unit one condition is met; write 1 clears.
// - compare flag zero sets when unit zero condition is met; write 1 clears.
// - single mode sets the done flag when the conversion ends.
// - scan mode sets the done flag only after all enabled channels end.
// - writing 1 to the done bit clears it; software acknowledges so.
// - an 18-bit read-only register shows the word the DMA moves.
// - that register shows whichever channel result is being transferred.
// - each compare unit counts matches, flags at threshold plus one.
// - a set compare flag with its enable raises a compare request.
//
// Purpose: status, flag and DMA monitor registers of the converter
// Assumes: converter core, result registers and DMA share clk
// Notes: one wait state on every bus access
`timescale 1ns/1ps
module asf_status_regs
	import asf_pkg::*;
#(
	parameter int NCH = ASF_NCH
) (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	// avalon-mm slave
	input  wire logic [ASF_ADDR_W-1:0]        address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [31:0]                  writedata,
	input  wire logic [3:0]                   byteenable,
	output logic [31:0]                       readdata,
	output logic                              waitrequest,
	// converter core
	input  wire logic                         conversion_start_bit,
	input  wire logic                         scan_mode,
	input  wire logic [2:0]                   cur_channel,
	input  wire logic [2:0]                   next_channel,
	input  wire logic [NCH-1:0]               chan_enable,
	input  wire logic                         chan_done,
	input  wire logic [2:0]                   chan_done_num,
	// result registers
	input  wire logic [NCH-1:0]               chan_valid,
	input  wire logic [NCH-1:0]               chan_overrun,
	input  wire logic [NCH*ASF_RES_W-1:0]     channel_result_register,
	input  wire logic                         res_stb,
	input  wire logic [2:0]                   res_chan,
	input  wire logic [ASF_DATA_W-1:0]        res_data,
	// compare settings, unit zero then one
	input  wire logic [1:0]                   cmp_en,
	input  wire logic [1:0]                   cmp_cond,
	input  wire logic [5:0]                   cmp_chan,
	input  wire logic [2*ASF_DATA_W-1:0]      cmp_data,
	input  wire logic [2*ASF_MCNT_W-1:0]      match_count_threshold,
	input  wire logic [1:0]                   compare_irq_enable,
	// dma engine
	input  wire logic                         dma_active,
	input  wire logic [2:0]                   dma_chan,
	// requests
	output logic                              cmp_irq,
	output logic                              irq
);
	import asf_pkg::*;

	logic                  ack_q;
	logic                  wr_ok;
	logic                  rd_ok;
	logic [31:0]           rdata_q;
	logic [31:0]           status_w;
	logic [ASF_RES_W-1:0]  dma_monitor_value_q;
	logic [ASF_NFLAG-1:0]  mask_q;
	logic [ASF_NFLAG-1:0]  flag_q;
	logic [ASF_NFLAG-1:0]  flag_set;
	logic [ASF_NFLAG-1:0]  flag_clr;
	logic [1:0]            cmp_match;
	logic [NCH-1:0]        scan_seen_q;
	logic [NCH-1:0]        seen_now;
	logic                  scan_all;
	logic                  done_set;

	// field widths are fixed by the register layout
	if (NCH != 8) begin : g_chk
		$error("asf_status_regs supports exactly 8 channels");
	end

	// one wait state: request seen, answered next edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read || write) && !ack_q;
		end
	end

	assign waitrequest = (read || write) && !ack_q;
	assign wr_ok       = write && ack_q;
	assign rd_ok       = read && ack_q;

	// live status word, reserved bits zero
	always_comb begin
		status_w                             = ASF_RST_WORD;
		status_w[ASF_OVR_LO +: NCH]          = chan_overrun;
		status_w[ASF_VALID_LO +: NCH]        = chan_valid;
		status_w[ASF_CH_LO +: 3]             = conversion_start_bit ?
		                                       cur_channel : next_channel;
		status_w[ASF_B_BUSY]                 = conversion_start_bit;
		status_w[ASF_B_DONE]                 = flag_q[ASF_B_DONE];
		status_w[ASF_B_COMPARE_FLAG_ZERO]                = flag_q[ASF_B_COMPARE_FLAG_ZERO];
		status_w[ASF_B_COMPARE_FLAG_ONE]                = flag_q[ASF_B_COMPARE_FLAG_ONE];
	end

	// read data captured in the wait cycle, held to the answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= ASF_RST_WORD;
		end else if (read && !ack_q) begin
			case (address)
				ASF_OFS_STATUS:  rdata_q <= status_w;
				ASF_OFS_DMAMON:  rdata_q <= {{(32-ASF_RES_W){1'b0}}, dma_monitor_value_q};
				ASF_OFS_IRQMASK: rdata_q <= {{(32-ASF_NFLAG){1'b0}}, mask_q};
				default:         rdata_q <= ASF_RST_WORD; // unmapped reads zero
			endcase
		end
	end

	assign readdata = rdata_q;

	// interrupt mask, same layout as the flag bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= ASF_RST_MASK;
		end else if (wr_ok && address == ASF_OFS_IRQMASK && byteenable[0]) begin
			mask_q <= writedata[ASF_NFLAG-1:0];
		end
	end

	// dma monitor follows the channel under transfer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dma_monitor_value_q <= '0;
		end else if (dma_active) begin
			dma_monitor_value_q <= channel_result_register[dma_chan*ASF_RES_W +: ASF_RES_W];
		end
	end

	// compare units
	for (genvar u = 0; u < 2; u++) begin : g_cmp
		asf_cmp_unit u_cmp (
			.clk                   (clk),
			.arst_n                (arst_n),
			.cmp_en                (cmp_en[u]),
			.cmp_cond              (cmp_cond[u]),
			.cmp_chan              (cmp_chan[u*3 +: 3]),
			.cmp_data              (cmp_data[u*ASF_DATA_W +: ASF_DATA_W]),
			.match_count_threshold (match_count_threshold[u*ASF_MCNT_W +: ASF_MCNT_W]),
			.res_stb               (res_stb),
			.res_chan              (res_chan),
			.res_data              (res_data),
			.match_o               (cmp_match[u])
		);
	end

	// scan bookkeeping: channels finished this round
	assign seen_now = scan_seen_q | (chan_done ? (NCH'(1) << chan_done_num) : '0);
	assign scan_all = (chan_enable != '0) && ((seen_now & chan_enable) == chan_enable);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scan_seen_q <= '0;
		end else if (!scan_mode || (chan_done && scan_all)) begin
			scan_seen_q <= '0; // new round
		end else begin
			scan_seen_q <= seen_now;
		end
	end

	// done sets per mode
	assign done_set = chan_done && (scan_mode ? scan_all : 1'b1);

	// flag set sources
	assign flag_set[ASF_B_DONE]  = done_set;
	assign flag_set[ASF_B_COMPARE_FLAG_ZERO] = cmp_match[0];
	assign flag_set[ASF_B_COMPARE_FLAG_ONE] = cmp_match[1];

	// sticky flags, cleared only by a one in byte lane 0
	for (genvar f = 0; f < ASF_NFLAG; f++) begin : g_flag
		assign flag_clr[f] = wr_ok && address == ASF_OFS_STATUS
		                   && byteenable[0] && writedata[f];
		asf_w1c_flag u_flag (
			.clk    (clk),
			.arst_n (arst_n),
			.set_i  (flag_set[f]),
			.clr_i  (flag_clr[f]),
			.flag_q (flag_q[f])
		);
	end

	// compare request and masked interrupt
	assign cmp_irq = (flag_q[ASF_B_COMPARE_FLAG_ZERO] && compare_irq_enable[0])
	               || (flag_q[ASF_B_COMPARE_FLAG_ONE] && compare_irq_enable[1]);
	assign irq     = |(flag_q & mask_q);

	// checks
	AST_OVR_MIRROR: assert property (@(posedge clk) disable iff (!arst_n)
		rd_ok && address == ASF_OFS_STATUS
		|-> readdata[ASF_OVR_LO +: NCH] == $past(chan_overrun))
		else $error("overrun field wrong");

	AST_VALID_MIRROR: assert property (@(posedge clk) disable iff (!arst_n)
		rd_ok && address == ASF_OFS_STATUS
		|-> readdata[ASF_VALID_LO +: NCH] == $past(chan_valid))
		else $error("valid field wrong");

	AST_CHAN_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
		rd_ok && address == ASF_OFS_STATUS && $past(conversion_start_bit)
		|-> readdata[ASF_CH_LO +: 3] == $past(cur_channel) && readdata[ASF_B_BUSY])
		else $error("busy channel wrong");

	AST_CHAN_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
		rd_ok && address == ASF_OFS_STATUS && !$past(conversion_start_bit)
		|-> readdata[ASF_CH_LO +: 3] == $past(next_channel) && !readdata[ASF_B_BUSY])
		else $error("idle channel wrong");

	AST_COMPARE_FLAG_ZERO_SET: assert property (@(posedge clk) disable iff (!arst_n)
		cmp_match[0] |=> flag_q[ASF_B_COMPARE_FLAG_ZERO])
		else $error("compare flag zero not set");

	AST_COMPARE_FLAG_ONE_SET: assert property (@(posedge clk) disable iff (!arst_n)
		cmp_match[1] |=> flag_q[ASF_B_COMPARE_FLAG_ONE])
		else $error("compare flag one not set");

	AST_SINGLE_DONE: assert property (@(posedge clk) disable iff (!arst_n)
		chan_done && !scan_mode |=> flag_q[ASF_B_DONE])
		else $error("single done not flagged");

	AST_SCAN_PARTIAL: assert property (@(posedge clk) disable iff (!arst_n)
		scan_mode && !flag_q[ASF_B_DONE] && !scan_all |=> !flag_q[ASF_B_DONE])
		else $error("scan done set early");

	AST_DONE_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
		flag_clr[ASF_B_DONE] && !done_set |=> !flag_q[ASF_B_DONE])
		else $error("done not cleared");

	AST_ZERO_KEEPS: assert property (@(posedge clk) disable iff (!arst_n)
		wr_ok && address == ASF_OFS_STATUS && !writedata[ASF_B_COMPARE_FLAG_ZERO]
		&& flag_q[ASF_B_COMPARE_FLAG_ZERO] |=> flag_q[ASF_B_COMPARE_FLAG_ZERO])
		else $error("zero write cleared flag");

	AST_DMA_FOLLOW: assert property (@(posedge clk) disable iff (!arst_n)
		dma_active |=> dma_monitor_value_q
		== $past(channel_result_register[dma_chan*ASF_RES_W +: ASF_RES_W]))
		else $error("dma monitor stale");

	AST_CMP_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
		cmp_match[0] && compare_irq_enable[0] ##1 compare_irq_enable[0] |-> cmp_irq)
		else $error("compare request missing");
endmodule : asf_status_regs

// [core/asf_pkg.sv]
// Purpose: shared constants for the converter status and flag logic
// Assumes: 32-bit Avalon-MM register slave with byte addresses
// Notes: own registers sit above the printed map
package asf_pkg;
	localparam int          ASF_NCH         = 8;
	localparam int          ASF_RES_W       = 18;
	localparam int          ASF_DATA_W      = 12;
	localparam int          ASF_MCNT_W      = 4;
	localparam int          ASF_ADDR_W      = 8;
	// register byte offsets
	localparam logic [7:0]  ASF_OFS_STATUS  = 8'h30;
	localparam logic [7:0]  ASF_OFS_DMAMON  = 8'h40;
	localparam logic [7:0]  ASF_OFS_IRQMASK = 8'h50;
	// status field positions
	localparam int          ASF_B_DONE      = 0;
	localparam int          ASF_B_COMPARE_FLAG_ZERO     = 1;
	localparam int          ASF_B_COMPARE_FLAG_ONE     = 2;
	localparam int          ASF_B_BUSY      = 3;
	localparam int          ASF_CH_LO       = 4;
	localparam int          ASF_VALID_LO    = 8;
	localparam int          ASF_OVR_LO      = 16;
	localparam int          ASF_NFLAG       = 3;
	// reset values
	localparam logic [31:0] ASF_RST_WORD    = 32'h0000_0000;
	localparam logic [2:0]  ASF_RST_MASK    = 3'h0;
endpackage : asf_pkg

// [core/asf_w1c_flag.sv]
// Purpose: one sticky flag set by hardware, cleared by software
// Assumes: set and clear are single-cycle strobes on clk
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module asf_w1c_flag (
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// strobes
	input  wire logic set_i,
	input  wire logic clr_i,
	// state
	output logic      flag_q
);
	// set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= 1'b0;
		end else if (set_i) begin
			flag_q <= 1'b1;
		end else if (clr_i) begin
			flag_q <= 1'b0;
		end
	end
endmodule : asf_w1c_flag

// [core/asf_cmp_unit.sv]
// Purpose: one compare unit with its match counter
// Assumes: result strobe and settings come from logic on clk
// Notes: match_o pulses when the count reaches threshold plus one
`timescale 1ns/1ps
module asf_cmp_unit
	import asf_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	// settings
	input  wire logic                  cmp_en,
	input  wire logic                  cmp_cond,
	input  wire logic [2:0]            cmp_chan,
	input  wire logic [ASF_DATA_W-1:0] cmp_data,
	input  wire logic [ASF_MCNT_W-1:0] match_count_threshold,
	// result strobe
	input  wire logic                  res_stb,
	input  wire logic [2:0]            res_chan,
	input  wire logic [ASF_DATA_W-1:0] res_data,
	// match pulse
	output logic                       match_o
);
	logic [ASF_MCNT_W:0] cnt_q;
	logic                hit;
	logic                reach;

	// qualifying result: cond 1 means greater or equal
	assign hit   = cmp_en && res_stb && (res_chan == cmp_chan)
	             && (cmp_cond ? (res_data >= cmp_data) : (res_data < cmp_data));
	assign reach = hit && ((cnt_q + 1'b1) == ({1'b0, match_count_threshold} + 1'b1));

	// match counter, restarts after each flag
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (!cmp_en || reach) begin
			cnt_q <= '0;
		end else if (hit) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign match_o = reach;

	AST_CMP_REACH: assert property (@(posedge clk) disable iff (!arst_n)
		match_o |-> (cnt_q == {1'b0, match_count_threshold}))
		else $error("match pulse at wrong count");
endmodule : asf_cmp_unit

// [test/asf_dma_model.sv]
// Purpose: model of the DMA engine that moves channel results
// Assumes: start is a one-cycle strobe from the bench
// Notes: slow transfers stall for extra cycles
`timescale 1ns/1ps
module asf_dma_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// command from bench
	input  wire logic       start,
	input  wire logic       slow,
	input  wire logic [2:0] chan,
	// towards the block
	output logic            dma_active,
	output logic [2:0]      dma_chan
);
	logic [2:0] left_q;
	// one transfer per start, held longer when slow
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			left_q     <= 3'h0;
			dma_active <= 1'b0;
			dma_chan   <= 3'h0;
		end else if (start) begin
			left_q     <= slow ? 3'h3 : 3'h0;
			dma_active <= 1'b1;
			dma_chan   <= chan;
		end else if (left_q != 3'h0) begin
			left_q <= left_q - 3'h1;
		end else if (dma_active) begin
			dma_active <= 1'b0;
			dma_chan   <= ~dma_chan; // released lines lose the value
		end
	end
endmodule : asf_dma_model

// [test/test_asf_status_regs.sv]
// Purpose: self-checking bench for the status and flag registers
// Assumes: one wait state per bus access
// Notes: read results checked from a queue at the answer
`timescale 1ns/1ps
module test_asf_status_regs;
	import asf_pkg::*;
	logic         clk, arst_n, read, write, busy, scan, cdone, stb, dstart, dslow;
	logic         waitrequest, cmp_irq, irq, dma_active;
	logic [7:0]   address, ven, vovr, chen, cthr;
	logic [31:0]  writedata, readdata;
	logic [3:0]   byteenable;
	logic [2:0]   cur, nxt, dch, rch, dmac, dsel;
	logic [143:0] res;
	logic [11:0]  rdat;
	logic [1:0]   cen, cco, cie;
	logic [5:0]   cch;
	logic [23:0]  cdat;
	logic [31:0]  exp_q[$];
	string        nm_q[$];
	int           bad_count, checks_done;

	asf_status_regs dut (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .conversion_start_bit(busy),
		.scan_mode(scan), .cur_channel(cur), .next_channel(nxt), .chan_enable(chen),
		.chan_done(cdone), .chan_done_num(dch), .chan_valid(ven), .chan_overrun(vovr),
		.channel_result_register(res), .res_stb(stb), .res_chan(rch), .res_data(rdat),
		.cmp_en(cen), .cmp_cond(cco), .cmp_chan(cch), .cmp_data(cdat),
		.match_count_threshold(cthr), .compare_irq_enable(cie), .dma_active(dma_active),
		.dma_chan(dmac), .cmp_irq(cmp_irq), .irq(irq));
	asf_dma_model dma (.clk(clk), .arst_n(arst_n), .start(dstart), .slow(dslow),
		.chan(dsel), .dma_active(dma_active), .dma_chan(dmac));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ok;
		@(posedge clk);
		address   <= a;
		writedata <= d;
		read      <= !w;
		write     <= w;
		ok = 1'b0;
		while (!ok) begin
			@(negedge clk);
			ok = !waitrequest;
			@(posedge clk);
		end
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		bus(1'b0, a, 32'h0);
	endtask : rd

	function automatic logic [31:0] st(input logic [2:0] f);
		return {8'h00, vovr, ven, 1'b0, busy ? cur : nxt, busy, f};
	endfunction : st

	task automatic done_p(input logic [2:0] c);
		@(posedge clk);
		cdone <= 1'b1;
		dch   <= c;
		@(posedge clk);
		cdone <= 1'b0;
	endtask : done_p

	task automatic res_p(input logic [2:0] c, input logic [11:0] d);
		@(posedge clk);
		stb  <= 1'b1;
		rch  <= c;
		rdat <= d;
		@(posedge clk);
		stb <= 1'b0;
	endtask : res_p

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	// compare each read answer with the oldest note
	always @(negedge clk) begin
		if (read && !waitrequest && exp_q.size() > 0)
			chk(nm_q.pop_front(), exp_q.pop_front(), readdata);
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test;
	end

	// main sequence
	initial begin
		{arst_n, read, write, busy, scan, cdone, stb, dstart, dslow} = '0;
		{address, ven, vovr, chen, cthr, writedata, cur, nxt, dch, rch, dsel} = '0;
		{rdat, cen, cco, cie, cch, cdat} = '0;
		byteenable = 4'hf;
		void'($urandom(64840));
		for (int i = 0; i < 8; i++)
			res[18*i +: 18] = 18'($urandom);
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rd(ASF_OFS_STATUS, 32'h0, "status");
		rd(ASF_OFS_DMAMON, 32'h0, "dmamon");
		rd(8'h20, 32'h0, "unmapped");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ven  <= 8'($urandom);
			vovr <= 8'($urandom);
			cur  <= 3'($urandom);
			nxt  <= 3'($urandom);
			busy <= i[0];
			@(negedge clk);
			rd(ASF_OFS_STATUS, st(3'h0), "status");
		end
		bus(1'b1, ASF_OFS_STATUS, 32'hffff_fff8);
		rd(ASF_OFS_STATUS, st(3'h0), "status");
		$display("test mirror done");
		done_p(3'h2);
		rd(ASF_OFS_STATUS, st(3'h1), "status");
		bus(1'b1, ASF_OFS_STATUS, 32'h0);
		rd(ASF_OFS_STATUS, st(3'h1), "status");
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, ASF_OFS_IRQMASK, 32'h1);
		rd(ASF_OFS_IRQMASK, 32'h1, "mask");
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, ASF_OFS_STATUS, 32'h1);
		rd(ASF_OFS_STATUS, st(3'h0), "status");
		chk("irq", 32'h0, {31'h0, irq});
		@(posedge clk);
		scan <= 1'b1;
		chen <= 8'h05;
		done_p(3'h0);
		rd(ASF_OFS_STATUS, st(3'h0), "status");
		done_p(3'h2);
		rd(ASF_OFS_STATUS, st(3'h1), "status");
		bus(1'b1, ASF_OFS_STATUS, 32'h1);
		$display("test done flag done");
		@(posedge clk);
		cen  <= 2'b11;
		cco  <= 2'b01;
		cch  <= {3'h5, 3'h3};
		cdat <= {12'h200, 12'h100};
		cthr <= {4'h0, 4'h1};
		cie  <= 2'b01;
		res_p(3'h3, 12'h180);
		res_p(3'h4, 12'hfff);
		res_p(3'h3, 12'h0ff);
		res_p(3'h5, 12'h100);
		rd(ASF_OFS_STATUS, st(3'h4), "status");
		chk("cmp_irq", 32'h0, {31'h0, cmp_irq});
		res_p(3'h3, 12'h300);
		rd(ASF_OFS_STATUS, st(3'h6), "status");
		chk("cmp_irq", 32'h1, {31'h0, cmp_irq});
		bus(1'b1, ASF_OFS_STATUS, 32'h1);
		rd(ASF_OFS_STATUS, st(3'h6), "status");
		bus(1'b1, ASF_OFS_STATUS, 32'h6);
		rd(ASF_OFS_STATUS, st(3'h0), "status");
		chk("cmp_irq", 32'h0, {31'h0, cmp_irq});
		$display("test compare done");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			dsel   <= 3'($urandom);
			dslow  <= i[0];
			dstart <= 1'b1;
			@(posedge clk);
			dstart <= 1'b0;
			repeat (8) @(posedge clk);
			rd(ASF_OFS_DMAMON, {14'h0, res[18*dsel +: 18]}, "dmamon");
		end
		bus(1'b1, ASF_OFS_DMAMON, 32'hffff_ffff);
		rd(ASF_OFS_DMAMON, {14'h0, res[18*dsel +: 18]}, "dmamon");
		$display("test dma done");
		repeat (4) @(posedge clk);
		stop_test;
	end
endmodule : test_asf_status_regs
